/* File: ten_bit_serdes_port.sv */
/*
  ten-bit interface port between a pcs core and an external serdes chip.
  assumes the serdes pins and receive clocks are asynchronous to clk_sys and much slower than it;
  the core side runs on clk_sys. one instance serves one serdes.
*/
// Functional notes
// - transmit code group and clock pins come straight from output flip-flops.
// - forwarded transmit clock made by a register, aligned with the data launch.
// - forwarded clock is inverted so its rise sits mid data window.
// - receive words captured alternately on even clock rise, then odd clock rise.
// - single-clock mode uses both edges of the even clock, ignoring odd.
// - single-clock mode presents both halves together at the even clock rise.
// - captured words are resampled at once into a register stage.
// - dual-clock mode takes the odd word straight from the shared sampler, not from a capture stage of its own.
// - transmit logic lives wholly in the shared system clock domain.
// - each instance owns its receive clocks and receive capture logic.
// - client byte strobe runs at 125, 12.5 or 1.25 MHz by speed.
`timescale 1ns/1ps
module ten_bit_serdes_port #(
  parameter int CODE_W = ten_bit_serdes_pkg::CODE_W,
  parameter int FIFO_DEPTH = ten_bit_serdes_pkg::RX_FIFO_DEPTH,
  parameter int TX_HALF = ten_bit_serdes_pkg::TX_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic singleClockMode,
  input wire ten_bit_serdes_pkg::speed_t speedSelect,
  input wire logic [CODE_W-1:0] txCodeGroup,
  input wire logic txValid,
  output logic txReady,
  output logic [CODE_W-1:0] txCodeGroupPin,
  output logic txClockPin,
  input wire logic [CODE_W-1:0] rxCodeGroupPin,
  input wire logic rx_clock_even,
  input wire logic rx_clock_odd,
  output ten_bit_serdes_pkg::codePair_t rxPair,
  output logic rxValid,
  input wire logic rxReady,
  output logic rxOverflow,
  output logic clientStrobe
);

  localparam int PAIR_W = 2 * CODE_W;
  localparam logic [ten_bit_serdes_pkg::TX_CNT_W-1:0] TX_LAST =
    ten_bit_serdes_pkg::TX_CNT_W'(TX_HALF - 1);

  // ---------------- transmit path, all on clk_sys ----------------
  logic [ten_bit_serdes_pkg::TX_CNT_W-1:0] txCnt_reg;
  logic [CODE_W-1:0] txHold_reg;
  logic txHoldFull_reg;
  logic txToggle;
  logic txLaunch;

  assign txToggle = (txCnt_reg == TX_LAST);
  // data launches when the internal transmit phase rises, i.e. the forwarded clock falls
  assign txLaunch = txToggle && txClockPin;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txCnt_reg <= '0;
    end else if (txToggle) begin
      txCnt_reg <= '0;
    end else begin
      txCnt_reg <= txCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txClockPin <= 1'b1;
    end else if (txToggle) begin
      txClockPin <= ~txClockPin;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txHold_reg <= ten_bit_serdes_pkg::CODE_RESET;
      txHoldFull_reg <= 1'b0;
    end else if (txValid && txReady) begin
      txHold_reg <= txCodeGroup;
      txHoldFull_reg <= 1'b1;
    end else if (txLaunch) begin
      txHoldFull_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txReady <= 1'b0;
    end else begin
      txReady <= !txHoldFull_reg && !(txValid && txReady);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txCodeGroupPin <= ten_bit_serdes_pkg::CODE_RESET;
    end else if (txLaunch && txHoldFull_reg) begin
      txCodeGroupPin <= txHold_reg;
    end
  end

  // ---------------- receive capture, private to this instance ----------------
  logic [CODE_W-1:0] rxDataSync1_reg;
  logic [CODE_W-1:0] rxDataSync2_reg;
  logic [2:0] evenSync_reg;
  logic [2:0] oddSync_reg;
  logic evenRise;
  logic evenFall;
  logic oddRise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evenSync_reg <= '0;
      oddSync_reg <= '0;
      rxDataSync1_reg <= '0;
      rxDataSync2_reg <= '0;
    end else begin
      evenSync_reg <= {evenSync_reg[1:0], rx_clock_even};
      oddSync_reg <= {oddSync_reg[1:0], rx_clock_odd};
      rxDataSync1_reg <= rxCodeGroupPin;
      rxDataSync2_reg <= rxDataSync1_reg;
    end
  end

  assign evenRise = evenSync_reg[1] && !evenSync_reg[2];
  assign evenFall = !evenSync_reg[1] && evenSync_reg[2];
  // odd clock ignored in single mode
  assign oddRise = oddSync_reg[1] && !oddSync_reg[2] && !singleClockMode;

  logic [CODE_W-1:0] evenWord_reg;
  logic [CODE_W-1:0] oddWord_reg;
  logic evenHave_reg;
  logic oddHave_reg;
  logic pairPush;
  logic fifoInReady;
  ten_bit_serdes_pkg::codePair_t pairIn;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evenWord_reg <= '0;
    end else if (evenRise) begin
      evenWord_reg <= rxDataSync2_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oddWord_reg <= '0;
    end else if (oddRise || (singleClockMode && evenFall)) begin
      oddWord_reg <= rxDataSync2_reg;
    end
  end

  // pairing state: even word must come first, a stray odd word is dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evenHave_reg <= 1'b0;
      oddHave_reg <= 1'b0;
    end else if (singleClockMode) begin
      if (evenRise) begin
        evenHave_reg <= 1'b1;
        oddHave_reg <= 1'b0;
      end else if (evenFall && evenHave_reg) begin
        oddHave_reg <= 1'b1;
      end
    end else begin
      oddHave_reg <= 1'b0;
      if (evenRise) begin
        evenHave_reg <= 1'b1;
      end else if (oddRise) begin
        evenHave_reg <= 1'b0;
      end
    end
  end

  // single mode releases both halves at the next even rise
  // dual mode releases at odd rise
  assign pairPush = singleClockMode ? (evenRise && evenHave_reg && oddHave_reg)
                                    : (oddRise && evenHave_reg);

  always_comb begin
    pairIn.first = evenWord_reg;
    // dual mode takes the odd word straight from the sampler in the same cycle
    pairIn.second = singleClockMode ? oddWord_reg : rxDataSync2_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxOverflow <= 1'b0;
    end else if (pairPush && !fifoInReady) begin
      rxOverflow <= 1'b1;
    end
  end

  logic [PAIR_W-1:0] fifoOutData;
  logic fifoOutValid;
  logic fifoOutReady;

  assign fifoOutReady = !rxValid || rxReady;

  rx_pair_fifo #(
    .WIDTH(PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) pairFifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inData(pairIn),
    .inValid(pairPush),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxPair <= '0;
      rxValid <= 1'b0;
    end else if (fifoOutReady) begin
      rxValid <= fifoOutValid;
      if (fifoOutValid) begin
        rxPair <= ten_bit_serdes_pkg::codePair_t'(fifoOutData);
      end
    end
  end

  // ---------------- client byte rate strobe ----------------
  logic [ten_bit_serdes_pkg::DIV_W-1:0] rateCnt_reg;
  logic [ten_bit_serdes_pkg::DIV_W-1:0] rateLast;

  always_comb begin
    unique case (speedSelect)
      ten_bit_serdes_pkg::SPEED_10M: rateLast = ten_bit_serdes_pkg::DIV_W'(ten_bit_serdes_pkg::DIV_10M - 1);
      ten_bit_serdes_pkg::SPEED_100M: rateLast = ten_bit_serdes_pkg::DIV_W'(ten_bit_serdes_pkg::DIV_100M - 1);
      ten_bit_serdes_pkg::SPEED_1G: rateLast = ten_bit_serdes_pkg::DIV_W'(ten_bit_serdes_pkg::DIV_1G - 1);
      default: rateLast = ten_bit_serdes_pkg::DIV_W'(ten_bit_serdes_pkg::DIV_1G - 1);
    endcase
  end

  // strobe marks each new byte; repeats fill the gaps
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rateCnt_reg <= '0;
      clientStrobe <= 1'b0;
    end else if (rateCnt_reg >= rateLast) begin
      rateCnt_reg <= '0;
      clientStrobe <= 1'b1;
    end else begin
      rateCnt_reg <= rateCnt_reg + 1'b1;
      clientStrobe <= 1'b0;
    end
  end

endmodule : ten_bit_serdes_port

/* File: ten_bit_serdes_pkg.sv */
/*
  shared constants and carrier types for the ten-bit serdes port.
  assumes a single 125 MHz system clock; nothing is imported, users write the package name.
*/
package ten_bit_serdes_pkg;

  localparam int CODE_W = 10;
  localparam int RX_FIFO_DEPTH = 8;

  // system clock rate and client-side byte rates, in kHz
  localparam int CLK_SYS_KHZ = 125000;
  localparam int CLIENT_1G_KHZ = 125000;
  localparam int CLIENT_100M_KHZ = 12500;
  localparam int CLIENT_10M_KHZ = 1250;
  localparam int DIV_1G = CLK_SYS_KHZ / CLIENT_1G_KHZ;
  localparam int DIV_100M = CLK_SYS_KHZ / CLIENT_100M_KHZ;
  localparam int DIV_10M = CLK_SYS_KHZ / CLIENT_10M_KHZ;
  localparam int DIV_W = 7;

  // forwarded transmit clock half period, in system clock cycles
  localparam int TX_HALF_CYCLES = 1;
  localparam int TX_CNT_W = 8;

  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;

  // two successive code groups: first is the even-clock word, second the odd-clock word
  typedef struct packed {
    logic [CODE_W-1:0] first;
    logic [CODE_W-1:0] second;
  } codePair_t;

  typedef enum logic [1:0] {
    SPEED_10M,
    SPEED_100M,
    SPEED_1G
  } speed_t;

endpackage : ten_bit_serdes_pkg

/* File: rx_pair_fifo.sv */
/*
  flip-flop fifo with valid/ready on both sides.
  assumes one clock and synchronous active-high reset; outData is valid whenever outValid is high.
*/
`timescale 1ns/1ps
module rx_pair_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != FULL_COUNT);
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == LAST_PTR) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == LAST_PTR) ? '0 : rdPtr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : rx_pair_fifo

/* File: ten_bit_serdes_checker.sv */
/* concurrent checks on the ten-bit serdes port, bound to its top ports.
   assumes clk_sys with synchronous active-high rst and the package types. */
`timescale 1ns/1ps
module ten_bit_serdes_checker #(
  parameter int CODE_W = 10,
  parameter int TX_HALF = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ten_bit_serdes_pkg::speed_t speedSelect,
  input wire logic [CODE_W-1:0] txCodeGroup,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [CODE_W-1:0] txCodeGroupPin,
  input wire logic txClockPin,
  input wire ten_bit_serdes_pkg::codePair_t rxPair,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic rxOverflow,
  input wire logic clientStrobe
);
  localparam int TX_LAT = 2 * TX_HALF + 1;
  int lowCnt;
  int highCnt;
  logic [CODE_W-1:0] takenWord;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // length of each forwarded clock phase
  always_ff @(posedge clk_sys) begin
    lowCnt <= (rst || txClockPin) ? 0 : lowCnt + 1;
    highCnt <= (rst || !txClockPin) ? 0 : highCnt + 1;
  end
  always_ff @(posedge clk_sys) begin
    if (txValid && txReady) begin
      takenWord <= txCodeGroup;
    end
  end
  pin_launch_a: assert property (!$stable(txCodeGroupPin) |-> $fell(txClockPin))
    else $error("transmit pins moved off the forwarded clock fall");
  clk_low_a: assert property (!txClockPin |-> lowCnt < TX_HALF)
    else $error("forwarded clock low too long");
  clk_high_a: assert property (txClockPin |-> highCnt < TX_HALF)
    else $error("forwarded clock high too long");
  taken_word_a: assert property (txValid && txReady |-> ##[1:TX_LAT] txCodeGroupPin == takenWord)
    else $error("taken word not launched in time");
  ready_drop_a: assert property (txValid && txReady |=> !txReady)
    else $error("transmit ready stayed high after a take");
  rx_hold_a: assert property (rxValid && !rxReady |=> rxValid && $stable(rxPair))
    else $error("receive pair changed while stalled");
  ovf_sticky_a: assert property (rxOverflow |=> rxOverflow)
    else $error("overflow flag cleared without reset");
  strobe_slow_a: assert property (clientStrobe && speedSelect == ten_bit_serdes_pkg::SPEED_10M |=> !clientStrobe [*8])
    else $error("client strobe too frequent at lowest speed");
  cover property (txValid && txReady);
  cover property (rxValid && rxReady);
  cover property ($rose(rxOverflow));
endmodule : ten_bit_serdes_checker

bind ten_bit_serdes_port ten_bit_serdes_checker #(.CODE_W(CODE_W), .TX_HALF(TX_HALF)) ten_bit_serdes_checker_inst (
  .clk_sys(clk_sys),
  .rst(rst),
  .speedSelect(speedSelect),
  .txCodeGroup(txCodeGroup),
  .txValid(txValid),
  .txReady(txReady),
  .txCodeGroupPin(txCodeGroupPin),
  .txClockPin(txClockPin),
  .rxPair(rxPair),
  .rxValid(rxValid),
  .rxReady(rxReady),
  .rxOverflow(rxOverflow),
  .clientStrobe(clientStrobe)
);

/* File: serdes_model.sv */
/* behavioural external serdes: sends code-group pairs on two receive clocks.
   assumes the bench calls burst; clocks stand still between bursts. */
`timescale 1ns/1ps
module serdes_model (
  input wire logic singleClockMode,
  output logic [9:0] codeGroup,
  output logic clkEven,
  output logic clkOdd
);
  initial begin
    codeGroup = 10'h000;
    clkEven = 1'b0;
    clkOdd = 1'b0;
  end
  task automatic burst(input logic [9:0] base, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      codeGroup = base + 10'(i);
      #25;
      // even word on even rise, odd word on odd rise
      // single mode: rise then fall of the even clock
      if (singleClockMode) clkEven = ~clkEven;
      else {clkOdd, clkEven} = i[0] ? 2'b10 : 2'b01;
      #37.5;
      codeGroup = ~codeGroup;
      // stray odd rise with junk data after each fall, must be ignored
      if (singleClockMode) clkOdd = i[0];
    end
    // next even rise hands over the last single-mode pair
    if (singleClockMode) begin
      #25;
      clkEven = 1'b1;
    end else {clkOdd, clkEven} = 2'b00;
  endtask : burst
endmodule : serdes_model

/* File: tb_ten_bit_serdes_port.sv */
/* self-checking bench for the ten-bit serdes port with a serdes model.
   assumes the package and design files are compiled first. */
`timescale 1ns/1ps
module tb_ten_bit_serdes_port;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic singleClockMode = 1'b0;
  ten_bit_serdes_pkg::speed_t speedSelect = ten_bit_serdes_pkg::SPEED_1G;
  logic [9:0] txCodeGroup = 10'h000;
  logic txValid = 1'b0;
  logic rxReady = 1'b0;
  logic txReady, txClockPin, rx_clock_even, rx_clock_odd, rxValid, rxOverflow, clientStrobe;
  logic [9:0] txCodeGroupPin, rxCodeGroupPin;
  ten_bit_serdes_pkg::codePair_t rxPair;
  int n_mismatch = 0;
  int comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  ten_bit_serdes_port ten_bit_serdes_port_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .singleClockMode(singleClockMode),
    .speedSelect(speedSelect),
    .txCodeGroup(txCodeGroup),
    .txValid(txValid),
    .txReady(txReady),
    .txCodeGroupPin(txCodeGroupPin),
    .txClockPin(txClockPin),
    .rxCodeGroupPin(rxCodeGroupPin),
    .rx_clock_even(rx_clock_even),
    .rx_clock_odd(rx_clock_odd),
    .rxPair(rxPair),
    .rxValid(rxValid),
    .rxReady(rxReady),
    .rxOverflow(rxOverflow),
    .clientStrobe(clientStrobe)
  );
  serdes_model serdes_model_inst (.singleClockMode(singleClockMode), .codeGroup(rxCodeGroupPin),
    .clkEven(rx_clock_even), .clkOdd(rx_clock_odd));
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input logic [19:0] seen, input logic [19:0] expd);
    comparisons++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic do_reset(input logic single);
    rst = 1'b1;
    singleClockMode = single;
    repeat (10) step();
    check({txClockPin, txReady, rxValid, rxOverflow, clientStrobe, txCodeGroupPin}, 15'h4000);
    check(rxPair, 20'h00000);
    rst = 1'b0;
    repeat (2) step();
  endtask : do_reset
  task automatic tx_run;
    for (int k = 0; k < 6; k++) begin
      int t;
      t = 0;
      txCodeGroup = 10'h3c5 ^ 10'(k * 37);
      txValid = 1'b1;
      while (txReady !== 1'b1 && t < 10) begin
        step();
        t++;
      end
      step();
      check(txReady, 1'b0);
      t = 0;
      while (txCodeGroupPin !== txCodeGroup && t < 3) begin
        step();
        t++;
      end
      check(txCodeGroupPin, txCodeGroup);
      check(txClockPin, 1'b0);
    end
    txValid = 1'b0;
  endtask : tx_run
  task automatic collect(input logic [9:0] base, input int n);
    for (int k = 0; k < n; k++) begin
      int t;
      t = 0;
      while (rxValid !== 1'b1 && t < 400) begin
        step();
        t++;
      end
      check(rxPair, {base + 10'(2 * k), base + 10'(2 * k + 1)});
      step();
    end
  endtask : collect
  task automatic rx_run(input logic [9:0] base, input int n);
    step();
    rxReady = 1'b1;
    fork
      serdes_model_inst.burst(base, n);
      collect(base, n);
    join
    step();
  endtask : rx_run
  task automatic fill_run;
    rxReady = 1'b0;
    serdes_model_inst.burst(10'h200, 9);
    repeat (8) step();
    check(rxOverflow, 1'b0);
    serdes_model_inst.burst(10'h000, 1);
    repeat (8) step();
    check(rxOverflow, 1'b1);
    rxReady = 1'b1;
    collect(10'h200, 9);
    check(rxValid, 1'b0);
  endtask : fill_run
  task automatic strobe_run;
    int gap;
    int divs [3];
    divs = '{ten_bit_serdes_pkg::DIV_1G, ten_bit_serdes_pkg::DIV_100M, ten_bit_serdes_pkg::DIV_10M};
    for (int s = 0; s < 3; s++) begin
      speedSelect = ten_bit_serdes_pkg::speed_t'(2 - s);
      repeat (2) begin
        gap = 0;
        step();
        while (clientStrobe !== 1'b1 && gap < 300) begin
          step();
          gap++;
        end
      end
      check(20'(gap + 1), 20'(divs[s]));
    end
  endtask : strobe_run
  initial begin
    do_reset(1'b0);
    tx_run();
    rx_run(10'h100, 10);
    fill_run();
    strobe_run();
    do_reset(1'b1);
    rx_run(10'h280, 6);
    print_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_ten_bit_serdes_port
